// ===== hw/amc_pkg.sv
// Purpose: Shared constants and carriers for the amplifier mode control register
// Assumes: Eight-bit control, mask and gain registers from the serial bus slave
// Notes: Bit positions follow the register layout of the amplifier
`default_nettype none
package amc_pkg;

  // Control register width and reset value
  localparam int unsigned AMC_REG_W = 8;
  localparam logic [7:0] AMC_CTRL_RESET = 8'h00;

  // Control register field positions
  localparam int unsigned AMC_CTRL_POWER_DOWN = 0;
  localparam int unsigned AMC_CTRL_SRC_SEL = 1;
  localparam int unsigned AMC_CTRL_RSVD_LO = 2;
  localparam int unsigned AMC_CTRL_MUTE = 3;
  localparam int unsigned AMC_CTRL_RSVD_HI = 4;
  localparam int unsigned AMC_CTRL_CFG_SEL = 5;
  localparam int unsigned AMC_CTRL_BANK_SEL = 6;
  localparam int unsigned AMC_CTRL_BEEP_ON = 7;

  // Mask register field positions
  localparam int unsigned AMC_MASK_POWER_DOWN = 0;
  localparam int unsigned AMC_MASK_CFG = 1;
  localparam int unsigned AMC_MASK_BEEP = 2;

  // Gain register mute bits
  localparam int unsigned AMC_GAIN_MUTE_A = 6;
  localparam int unsigned AMC_GAIN_MUTE_B = 7;

  // Pin synchroniser depth and pin indices
  localparam int unsigned AMC_SYNC_STAGES = 2;
  localparam int unsigned AMC_PIN_COUNT = 2;
  localparam int unsigned AMC_PIN_SHUTDOWN_N = 0;
  localparam int unsigned AMC_PIN_CFG = 1;

  // Four gain registers of the two banks
  typedef struct packed {
    logic [7:0] bridge_tied_load_left;
    logic [7:0] bridge_tied_load_right;
    logic [7:0] single_ended_left;
    logic [7:0] single_ended_right;
  } amc_gain_t;

  // Decoded operating modes
  typedef struct packed {
    logic power_down;
    logic input_source_select;
    logic mute_left;
    logic mute_right;
    logic output_config_select;
    logic gain_bank_select;
    logic beep_force_on;
  } amc_mode_t;

  localparam amc_mode_t AMC_MODE_RESET = '0;

endpackage
`default_nettype wire

// ===== hw/amc_pin_sync.sv
// Purpose: Two-flop synchroniser for asynchronous external mode pins
// Assumes: Pins change slowly relative to ref_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module amc_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // Next values of both stages
  always_comb begin
    meta_next = pin_async;
    sync_next = meta_reg;
  end

  // Stage registers, cleared by reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pin_sync = sync_reg;

endmodule
`default_nettype wire

// ===== hw/amc_mode_ctrl.sv
// Purpose: Operating mode control register with mask-driven pin override
// Assumes: Serial bus slave delivers a one-cycle write strobe on ref_clk
// Notes: Mode outputs are registered one cycle behind the control value
// Contract
// - Control bit 0 high means power-down
// - Control bit 1 selects line or headphone input
// - Mask bit 1 routes source select to pin
// - Control bit 3 mutes like gain mutes
// - Control bit 5 selects bridge or single-ended
// - Control bit 6 selects gain register bank
// - Mask bit 1 ties bank to pin
// - Control bit 7 auto-detects or forces beep
// - Set mask bit 0 or 1 hands mode to pin
// - Beep mask forces beep auto-detect mode
// - Selected gain mute bits OR control mute
`timescale 1ns/1ns
`default_nettype none
module amc_mode_ctrl (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wr_valid,
  input wire logic [amc_pkg::AMC_REG_W-1:0] wr_data,
  input wire logic [amc_pkg::AMC_REG_W-1:0] mask_value,
  input wire amc_pkg::amc_gain_t gain_value,
  input wire logic shutdown_pin_n,
  input wire logic output_config_pin,
  output logic [amc_pkg::AMC_REG_W-1:0] ctrl_value,
  output amc_pkg::amc_mode_t mode
);
  import amc_pkg::*;

  logic [AMC_REG_W-1:0] ctrl_reg;
  logic [AMC_REG_W-1:0] ctrl_next;
  amc_mode_t mode_reg;
  amc_mode_t mode_next;
  logic [AMC_PIN_COUNT-1:0] pin_raw;
  logic [AMC_PIN_COUNT-1:0] pin_sync;
  logic pin_power_down;
  logic pin_cfg;
  logic bank_eff;
  logic [AMC_REG_W-1:0] gain_left_sel;
  logic [AMC_REG_W-1:0] gain_right_sel;

  // Pick the pin when masked, else the register bit
  function automatic logic pick_source(input logic masked, input logic pin_level,
                                       input logic reg_bit);
    pick_source = masked ? pin_level : reg_bit;
  endfunction

  // Either mute bit of a gain register silences its channel
  function automatic logic gain_muted(input logic [AMC_REG_W-1:0] gain);
    gain_muted = gain[AMC_GAIN_MUTE_A] | gain[AMC_GAIN_MUTE_B];
  endfunction

  // External pins cross into ref_clk
  assign pin_raw[AMC_PIN_SHUTDOWN_N] = shutdown_pin_n;
  assign pin_raw[AMC_PIN_CFG] = output_config_pin;

  amc_pin_sync #(
    .WIDTH(AMC_PIN_COUNT)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_async(pin_raw),
    .pin_sync(pin_sync)
  );

  // Shutdown pin is active low, internal bit active high
  assign pin_power_down = ~pin_sync[AMC_PIN_SHUTDOWN_N];
  assign pin_cfg = pin_sync[AMC_PIN_CFG];

  // Register write; reserved bits stored as written
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_valid) begin
      ctrl_next = wr_data;
    end
  end

  // Control register, cleared by reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_reg <= AMC_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Effective bank and the gain registers it selects
  always_comb begin
    bank_eff = pick_source(mask_value[AMC_MASK_CFG], pin_cfg,
                           ctrl_reg[AMC_CTRL_BANK_SEL]);
    gain_left_sel = bank_eff ? gain_value.single_ended_left :
                               gain_value.bridge_tied_load_left;
    gain_right_sel = bank_eff ? gain_value.single_ended_right :
                                gain_value.bridge_tied_load_right;
  end

  // Mode decode with mask override
  always_comb begin
    mode_next = AMC_MODE_RESET;
    mode_next.power_down = pick_source(mask_value[AMC_MASK_POWER_DOWN], pin_power_down,
                                       ctrl_reg[AMC_CTRL_POWER_DOWN]);
    mode_next.input_source_select = pick_source(mask_value[AMC_MASK_CFG], pin_cfg,
                                                ctrl_reg[AMC_CTRL_SRC_SEL]);
    mode_next.output_config_select = pick_source(mask_value[AMC_MASK_CFG], pin_cfg,
                                                 ctrl_reg[AMC_CTRL_CFG_SEL]);
    mode_next.gain_bank_select = bank_eff;
    // No beep pin: masked means auto-detect
    mode_next.beep_force_on = mask_value[AMC_MASK_BEEP] ? 1'b0 :
                              ctrl_reg[AMC_CTRL_BEEP_ON];
    mode_next.mute_left = ctrl_reg[AMC_CTRL_MUTE] | gain_muted(gain_left_sel);
    mode_next.mute_right = ctrl_reg[AMC_CTRL_MUTE] | gain_muted(gain_right_sel);
  end

  // Mode register, cleared by reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_reg <= AMC_MODE_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign ctrl_value = ctrl_reg;
  assign mode = mode_reg;

  // Write taken, then stored, then decoded
  sequence wr_take_s;
    wr_valid;
  endsequence

  sequence wr_store_s;
    ctrl_reg == $past(wr_data);
  endsequence

  property wr_to_mode_p;
    @(posedge ref_clk) disable iff (!nrst)
      (wr_take_s and !mask_value[AMC_MASK_BEEP]) ##1 (wr_store_s and !wr_valid)
        ##0 !mask_value[AMC_MASK_BEEP]
        |=> mode_reg.beep_force_on == $past(ctrl_reg[AMC_CTRL_BEEP_ON]);
  endproperty

  write_store_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_take_s |=> wr_store_s)
    else $error("control write not stored");

  write_mode_a: assert property (wr_to_mode_p)
    else $error("mode did not follow write");

  ctrl_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !wr_valid |=> $stable(ctrl_reg))
    else $error("control changed without write");

  reset_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(nrst) |-> (mode_reg == AMC_MODE_RESET) && (ctrl_reg == AMC_CTRL_RESET))
    else $error("reset did not clear state");

  power_down_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> mode_reg.power_down == ($past(mask_value[AMC_MASK_POWER_DOWN]) ?
      !$past(pin_sync[AMC_PIN_SHUTDOWN_N]) : $past(ctrl_reg[AMC_CTRL_POWER_DOWN])))
    else $error("power-down decode wrong");

  source_sel_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> mode_reg.input_source_select == ($past(mask_value[AMC_MASK_CFG]) ?
      $past(pin_cfg) : $past(ctrl_reg[AMC_CTRL_SRC_SEL])))
    else $error("input source decode wrong");

  config_sel_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) && !$past(mask_value[AMC_MASK_CFG]) |->
      mode_reg.output_config_select == $past(ctrl_reg[AMC_CTRL_CFG_SEL]))
    else $error("output config decode wrong");

  bank_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) && $past(mask_value[AMC_MASK_CFG]) |->
      mode_reg.gain_bank_select == mode_reg.output_config_select)
    else $error("bank not tied to pin");

  beep_mask_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(mask_value[AMC_MASK_BEEP]) |-> !mode_reg.beep_force_on)
    else $error("beep not in auto-detect");

  mute_or_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> mode_reg.mute_left == ($past(ctrl_reg[AMC_CTRL_MUTE]) |
      gain_muted($past(bank_eff) ? $past(gain_value.single_ended_left) :
                 $past(gain_value.bridge_tied_load_left))))
    else $error("left mute decode wrong");

  mute_right_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> mode_reg.mute_right == ($past(ctrl_reg[AMC_CTRL_MUTE]) |
      gain_muted($past(bank_eff) ? $past(gain_value.single_ended_right) :
                 $past(gain_value.bridge_tied_load_right))))
    else $error("right mute decode wrong");

  // Unmasked bank and beep follow their control bits
  bank_reg_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) && !$past(mask_value[AMC_MASK_CFG]) |->
      mode_reg.gain_bank_select == $past(ctrl_reg[AMC_CTRL_BANK_SEL]))
    else $error("gain bank decode wrong");

  beep_ctrl_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) && !$past(mask_value[AMC_MASK_BEEP]) |->
      mode_reg.beep_force_on == $past(ctrl_reg[AMC_CTRL_BEEP_ON]))
    else $error("beep decode wrong");

  // Masked configuration comes from the synchronised pin
  config_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) && $past(mask_value[AMC_MASK_CFG]) |->
      mode_reg.output_config_select == $past(pin_cfg))
    else $error("output config not from pin");

  // Masked shutdown pin held low across the synchroniser
  sequence pin_low_s;
    mask_value[AMC_MASK_POWER_DOWN] && !shutdown_pin_n;
  endsequence

  sequence pin_settled_s;
    pin_low_s ##1 pin_low_s ##1 pin_low_s;
  endsequence

  pin_shutdown_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    pin_settled_s |=> mode_reg.power_down)
    else $error("shutdown pin not followed");

  // Every reset edge leaves both registers cleared
  mode_clear_a: assert property (@(posedge ref_clk)
    !nrst |=> (mode_reg == AMC_MODE_RESET) && (ctrl_reg == AMC_CTRL_RESET))
    else $error("reset left state set");

endmodule
`default_nettype wire

// ===== testbench/amc_host_model.sv
// Purpose: Host side writer of the operating mode control byte
// Assumes: Bench moves req and req_data just after falling edges
// Notes: Reserved bits go out at their fixed levels
`timescale 1ns/1ns
`default_nettype none
module amc_host_model (
  input wire logic req,
  input wire logic [7:0] req_data,
  output logic wr_valid,
  output logic [7:0] wr_data
);
  logic [7:0] byte_out;
  // Bit 2 always low, bit 4 always high
  assign byte_out = {req_data[7:5], 1'b1, req_data[3], 1'b0, req_data[1:0]};
  // Strobe follows request; released data shows the inverse
  assign wr_valid = req;
  assign wr_data = req ? byte_out : ~byte_out;
endmodule
`default_nettype wire

// ===== testbench/tb_amp_mode_control_register.sv
// Purpose: Self-checking bench for the mode control register
// Assumes: Inputs move on falling edges of ref_clk
// Notes: Expected modes are decoded here from the bench's own state
`timescale 1ns/1ns
`default_nettype none
module tb_amp_mode_control_register;
  import amc_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic req = 1'b0;
  logic [7:0] req_data = 8'h00;
  logic wr_valid;
  logic [7:0] wr_data;
  logic [7:0] mask_value = 8'h00;
  amc_gain_t gain_value = '0;
  logic shutdown_pin_n = 1'b1;
  logic output_config_pin = 1'b0;
  logic [7:0] ctrl_value;
  amc_mode_t mode;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  amc_host_model host_u (.req(req), .req_data(req_data), .wr_valid(wr_valid),
    .wr_data(wr_data));
  amc_mode_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .wr_valid(wr_valid),
    .wr_data(wr_data), .mask_value(mask_value), .gain_value(gain_value),
    .shutdown_pin_n(shutdown_pin_n), .output_config_pin(output_config_pin),
    .ctrl_value(ctrl_value), .mode(mode));
  task automatic cmp_ctrl(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected ctrl at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic cmp_mode(input amc_mode_t got, input amc_mode_t exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected mode at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  // Reference decode of control byte, mask, pins and gains
  function automatic amc_mode_t exp_mode(input logic [7:0] c);
    amc_mode_t m;
    logic [7:0] gl;
    logic [7:0] gr;
    m.power_down = mask_value[0] ? ~shutdown_pin_n : c[0];
    m.input_source_select = mask_value[1] ? output_config_pin : c[1];
    m.output_config_select = mask_value[1] ? output_config_pin : c[5];
    m.gain_bank_select = mask_value[1] ? output_config_pin : c[6];
    m.beep_force_on = mask_value[2] ? 1'b0 : c[7];
    gl = m.gain_bank_select ? gain_value.single_ended_left :
                              gain_value.bridge_tied_load_left;
    gr = m.gain_bank_select ? gain_value.single_ended_right :
                              gain_value.bridge_tied_load_right;
    m.mute_left = c[3] | gl[7] | gl[6];
    m.mute_right = c[3] | gr[7] | gr[6];
    return m;
  endfunction
  // One write, readback after one edge, mode after two
  task automatic wr(input logic [7:0] d);
    logic [7:0] e;
    e = (d & 8'heb) | 8'h10;
    req = 1'b1;
    req_data = d;
    @(negedge ref_clk);
    req = 1'b0;
    cmp_ctrl(ctrl_value, e);
    @(negedge ref_clk);
    cmp_mode(mode, exp_mode(e));
  endtask
  task automatic s_bits;
    for (int i = 0; i < 8; i++) begin
      wr(8'h01 << i);
    end
    wr(8'h00);
  endtask
  task automatic s_b2b;
    req = 1'b1;
    req_data = 8'h81;
    @(negedge ref_clk);
    req_data = 8'h28;
    cmp_ctrl(ctrl_value, 8'h91);
    @(negedge ref_clk);
    req = 1'b0;
    cmp_ctrl(ctrl_value, 8'h38);
    cmp_mode(mode, exp_mode(8'h91));
    @(negedge ref_clk);
    cmp_mode(mode, exp_mode(8'h38));
  endtask
  // Mid-run reset clears a written register
  task automatic s_reset;
    wr(8'hff);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    cmp_ctrl(ctrl_value, 8'h00);
    cmp_mode(mode, '0);
    nrst = 1'b1;
    @(negedge ref_clk);
    cmp_ctrl(ctrl_value, 8'h00);
    cmp_mode(mode, exp_mode(8'h00));
  endtask
  task automatic s_mask;
    mask_value = 8'h07;
    shutdown_pin_n = 1'b0;
    output_config_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    wr(8'h00);
    shutdown_pin_n = 1'b1;
    output_config_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
    wr(8'hff);
    mask_value = 8'h00;
  endtask
  task automatic s_mute;
    gain_value.bridge_tied_load_left = 8'h80;
    gain_value.single_ended_right = 8'h40;
    wr(8'h00);
    wr(8'h40);
    wr(8'h08);
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    cmp_ctrl(ctrl_value, 8'h00);
    nrst = 1'b1;
    @(negedge ref_clk);
    cmp_mode(mode, '0);
    s_bits;
    s_b2b;
    s_mask;
    s_mute;
    s_reset;
    wrap_up;
  end
endmodule
`default_nettype wire
